// *** design/izs_interp_datapath.v ***
// Top of the interpolating datapath: input register, half-band interpolator, zero stuffing, code output.
// Assumes clk_sys is the converter update clock; sample and mode inputs are synchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "izs_map.vh"

module izs_interp_datapath (
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    input wire [13:0] sample_in,
    input wire filter_response_select,
    input wire zero_stuff_select,
    input wire div_reset,
    input wire mult_enable,
    output reg [13:0] dac_code_reg,
    output reg dac_valid_reg,
    output reg sample_taken_reg,
    output reg clk_1x_out_reg,
    output reg multiplier_lock_indicator_reg
);
    // Round Q15 accumulator to the code width, saturate, return offset binary
    function [13:0] izs_round_sat;
        input [39:0] acc;
        reg [39:0] sum;
        reg [24:0] shifted;
        reg [13:0] sat;
        begin
            sum = acc + `IZS_ROUND_HALF;
            shifted = sum[39:15];
            if (!shifted[24] && (shifted[23:13] != 11'h000)) begin
                sat = `IZS_SAT_MAX;
            end else if (shifted[24] && (shifted[23:13] != 11'h7FF)) begin
                sat = `IZS_SAT_MIN;
            end else begin
                sat = shifted[13:0];
            end
            izs_round_sat = {~sat[13], sat[12:0]};
        end
    endfunction

    // Signed product of a pair sum and a tap, sign-extended to the accumulator
    function [39:0] izs_mul;
        input [14:0] pair;
        input [16:0] coef;
        reg [31:0] prod;
        begin
            prod = $signed(pair) * $signed(coef);
            izs_mul = {{8{prod[31]}}, prod};
        end
    endfunction

    wire [1:0] phase;
    wire clk_1x;
    wire locked;

    izs_phase_gen u_phase (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .stuff_en(zero_stuff_select),
        .div_reset(div_reset),
        .mult_enable(mult_enable),
        .phase_reg(phase),
        .clk_1x_reg(clk_1x),
        .locked_reg(locked)
    );

    // Delay line of input samples in two's complement; entry 0 is the input register
    reg [13:0] line_reg [0:21];
    reg [4:0] fill_reg;
    wire [1:0] last_phase;
    wire load;
    integer i;

    assign last_phase = zero_stuff_select ? `IZS_PHASE_LAST_STUFF : `IZS_PHASE_LAST_PLAIN;
    // Rising edge of the internal 1x clock: the phase about to wrap to zero
    assign load = (phase == last_phase) || div_reset;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `IZS_LINE_LEN; i = i + 1) begin
                line_reg[i] <= 14'h0000;
            end
            fill_reg <= 5'h00;
        end else if (ce && load) begin
            line_reg[0] <= {~sample_in[13], sample_in[12:0]}; // see R1
            for (i = 1; i < `IZS_LINE_LEN; i = i + 1) begin
                line_reg[i] <= line_reg[i - 1];
            end
            if (fill_reg != 5'h16) begin
                fill_reg <= fill_reg + 5'h01;
            end
        end
    end

    // Symmetric pairs around the centre of the 43-tap response
    reg [16:0] tap;
    reg [14:0] pair;
    reg [39:0] acc_odd;
    reg [39:0] acc_even;
    reg [31:0] center_prod;
    reg [16:0] center_coef;

    always @* begin
        acc_odd = 40'h0000000000;
        tap = 17'h00000;
        pair = 15'h0000;
        for (i = 0; i <= `IZS_CENTER_IDX; i = i + 1) begin
            case (i)
                0: tap = `IZS_C_K21;
                1: tap = `IZS_C_K19;
                2: tap = `IZS_C_K17;
                3: tap = `IZS_C_K15;
                4: tap = `IZS_C_K13;
                5: tap = `IZS_C_K11;
                6: tap = `IZS_C_K9;
                7: tap = `IZS_C_K7;
                8: tap = `IZS_C_K5;
                9: tap = `IZS_C_K3;
                default: tap = `IZS_C_K1;
            endcase
            pair = {line_reg[i][13], line_reg[i]} + {line_reg[21 - i][13], line_reg[21 - i]}; // see R11
            acc_odd = acc_odd + izs_mul(pair, tap); // see R2
        end
        // Only the centre tap changes sign for the high-pass response
        center_coef = filter_response_select ? (~`IZS_CENTER_COEF + 17'h00001) : `IZS_CENTER_COEF; // see R3, R12
        center_prod = $signed(line_reg[`IZS_CENTER_IDX]) * $signed(center_coef);
        acc_even = {{8{center_prod[31]}}, center_prod};
    end

    // Output sequencing: plain mode is odd then even; stuffing puts midscale after each
    reg [13:0] code_next;
    wire [13:0] odd_code;
    wire [13:0] even_code;

    assign odd_code = izs_round_sat(acc_odd); // see R14
    assign even_code = izs_round_sat(acc_even); // see R14

    always @* begin
        code_next = `IZS_MIDSCALE;
        if (zero_stuff_select) begin
            case (phase) // see R4, R5, R6
                2'h0: code_next = odd_code;
                2'h1: code_next = `IZS_MIDSCALE; // see R10
                2'h2: code_next = even_code;
                2'h3: code_next = `IZS_MIDSCALE; // see R10
                default: code_next = `IZS_MIDSCALE;
            endcase
        end else begin
            case (phase) // see R7
                2'h0: code_next = odd_code;
                2'h1: code_next = even_code;
                default: code_next = even_code;
            endcase
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dac_code_reg <= `IZS_MIDSCALE;
            dac_valid_reg <= 1'b0;
            sample_taken_reg <= 1'b0;
            clk_1x_out_reg <= 1'b0;
            multiplier_lock_indicator_reg <= 1'b0;
        end else if (ce) begin
            dac_code_reg <= code_next; // see R8
            // Valid once the delay line holds a full set of real samples
            dac_valid_reg <= (fill_reg == 5'h16);
            sample_taken_reg <= load;
            clk_1x_out_reg <= clk_1x;
            // Lock level with the multiplier on, the 1x clock with it off
            multiplier_lock_indicator_reg <= mult_enable ? locked : clk_1x; // see R9
        end
    end
endmodule // izs_interp_datapath

`default_nettype wire

// *** design/izs_map.vh ***
// Constants for the interpolating zero-stuff datapath: widths, codes, timing and filter taps.
// Assumes a single system clock at the converter update rate; included by every design file.
// Functional notes
// R1: Each parallel input sample is caught in an edge-triggered input register on the rising edge of the input clock.
// R2: Every captured sample passes a two-times interpolation filter that yields two outputs per input.
// R3: Filter select low gives a low-pass response and high gives a high-pass response that keeps the upper image.
// R4: Zero-stuff select high enables zero stuffing and low bypasses it, independently of the filter select.
// R5: The two selects form four modes, baseband or direct IF, each with or without zero stuffing.
// R6: With zero stuffing on, the converter is updated four times per input sample.
// R7: With zero stuffing off, each filter output goes straight to the converter as the next code.
// R8: Input samples run up to 150 MSPS and the converter update path up to 400 MSPS.
// R9: With the multiplier on, all filter and converter timing comes from one reference clock and stays aligned.
// R10: Zero stuffing inserts one midscale code after every filter output, alternating the two.
// R11: The interpolator is a symmetric half-band FIR of 43 taps.
// R12: The high-pass set is the low-pass set with only the centre coefficient negated.
// R13: With the multiplier off, the data source may pulse the divider reset high to align the internal 1x clock.
// R14: Filter results are rounded and saturated to the 14-bit code before stuffing or conversion.
// R15: The data source keeps both mode selects static while running, since a change may corrupt samples in flight.
`ifndef IZS_MAP_VH
`define IZS_MAP_VH

`define IZS_CODE_W 14
`define IZS_MIDSCALE 14'h2000
`define IZS_SAT_MAX 14'h1FFF
`define IZS_SAT_MIN 14'h2000
`define IZS_TAPS 43
`define IZS_LINE_LEN 22
`define IZS_CENTER_IDX 10
`define IZS_COEF_W 17
`define IZS_COEF_FRAC 15
`define IZS_ACC_W 40
`define IZS_ROUND_HALF 40'h0000004000

// Last phase index per input sample, plain and stuffed
`define IZS_PHASE_LAST_PLAIN 2'h1
`define IZS_PHASE_LAST_STUFF 2'h3

// Rate limits in MSPS and the system clock in MHz
`define IZS_IN_RATE_MAX_MSPS 150
`define IZS_DAC_RATE_MAX_MSPS 400
`define IZS_CLK_MHZ 250

// Doubled half-band taps, Q15, for odd offsets 1..21 from the centre; centre is unity
`define IZS_CENTER_COEF 17'h08000
`define IZS_C_K1 17'h0517D
`define IZS_C_K3 17'h1E4D6
`define IZS_C_K5 17'h0104C
`define IZS_C_K7 17'h1F45C
`define IZS_C_K9 17'h0090E
`define IZS_C_K11 17'h1F898
`define IZS_C_K13 17'h00645
`define IZS_C_K15 17'h1FA91
`define IZS_C_K17 17'h004CB
`define IZS_C_K19 17'h1FBB6
`define IZS_C_K21 17'h003E1

`endif

// *** design/izs_phase_gen.v ***
// Divider that derives the per-sample update phases and the internal 1x clock from the system clock.
// Assumes the divider reset and multiplier enable are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "izs_map.vh"

module izs_phase_gen (
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    input wire stuff_en,
    input wire div_reset,
    input wire mult_enable,
    output reg [1:0] phase_reg,
    output reg clk_1x_reg,
    output reg locked_reg
);
    wire [1:0] last_phase;
    reg [1:0] phase_next;

    assign last_phase = stuff_en ? `IZS_PHASE_LAST_STUFF : `IZS_PHASE_LAST_PLAIN; // see R6

    always @* begin
        if (div_reset) begin
            phase_next = 2'h0; // see R13
        end else if (phase_reg >= last_phase) begin
            phase_next = 2'h0;
        end else begin
            phase_next = phase_reg + 2'h1;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 2'h0;
            clk_1x_reg <= 1'b0;
            locked_reg <= 1'b0;
        end else if (ce) begin
            phase_reg <= phase_next;
            // High during the first half of each input period
            // Phase 1 stays high only when continuing a high phase 0, so no short pulse after reset
            clk_1x_reg <= stuff_en ? ((phase_next == 2'h0) || ((phase_next == 2'h1) && clk_1x_reg)) :
                (phase_next == 2'h0);
            // Lock is declared the first time the phase count is at its last phase with the multiplier on
            if (!mult_enable || div_reset) begin
                locked_reg <= 1'b0;
            end else if (phase_reg == last_phase) begin
                locked_reg <= 1'b1; // see R9
            end
        end
    end
endmodule // izs_phase_gen

`default_nettype wire

// *** test/izs_dp_monitor.sv ***
// Checker for the outputs of the interpolating datapath.
// Assumes a bind to izs_interp_datapath in a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module izs_dp_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic zero_stuff_select,
    input wire logic div_reset,
    input wire logic mult_enable,
    input wire logic [13:0] dac_code_reg,
    input wire logic dac_valid_reg,
    input wire logic sample_taken_reg,
    input wire logic clk_1x_out_reg,
    input wire logic multiplier_lock_indicator_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    // Divider realignment restarts the phase count, so spacing checks pause there
    default disable iff (!rst_n || div_reset);
    plain_period_a: assert property (sample_taken_reg && !zero_stuff_select |=> !sample_taken_reg ##1 sample_taken_reg)
        else $error("plain sample spacing wrong");
    stuff_period_a: assert property (sample_taken_reg && zero_stuff_select |=> !sample_taken_reg [*3] ##1 sample_taken_reg)
        else $error("stuffed sample spacing wrong");
    stuff_midscale_a: assert property (sample_taken_reg && zero_stuff_select |-> ##2 dac_code_reg == 14'h2000 ##2 dac_code_reg == 14'h2000)
        else $error("midscale not inserted");
    reset_midscale_a: assert property ($rose(rst_n) |-> dac_code_reg == 14'h2000 && !sample_taken_reg)
        else $error("reset code not midscale");
    valid_hold_a: assert property (dac_valid_reg |=> dac_valid_reg)
        else $error("valid dropped");
    clk_plain_a: assert property ((!zero_stuff_select) [*4] |-> $changed(clk_1x_out_reg))
        else $error("1x clock not half rate");
    clk_stuff_a: assert property (zero_stuff_select && $changed(clk_1x_out_reg) |=> $stable(clk_1x_out_reg) ##1 $changed(clk_1x_out_reg))
        else $error("1x clock not quarter rate");
    lock_rise_a: assert property (mult_enable [*8] ##1 mult_enable [*4] |-> multiplier_lock_indicator_reg)
        else $error("lock not reached");
    ind_clock_a: assert property ((!mult_enable && !zero_stuff_select) [*4] |-> $changed(multiplier_lock_indicator_reg))
        else $error("indicator not following 1x clock");
endmodule // izs_dp_monitor
`default_nettype wire

// *** test/izs_src_model.sv ***
// Data source model: presents one table entry per capture.
// Assumes sample_taken_reg marks each capture; drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module izs_src_model (
    input wire logic clk_sys,
    input wire logic sample_taken_reg,
    output logic [13:0] sample_in
);
    logic [13:0] mem [0:63];
    int idx = 0;
    // Next sample only once the previous one is taken, so the load rate is never exceeded
    always @(negedge clk_sys) begin
        if (sample_taken_reg === 1'b1) begin
            idx <= idx + 1;
        end
    end
    assign sample_in = mem[idx[5:0]];
endmodule // izs_src_model
`default_nettype wire

// *** test/izs_interp_datapath_tb.sv ***
// Self-checking bench for the interpolating datapath in its four modes.
// Assumes the source model and the checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module izs_interp_datapath_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic filter_response_select = 1'b0;
    logic zero_stuff_select = 1'b0;
    logic div_reset = 1'b0;
    logic mult_enable = 1'b0;
    wire logic [13:0] sample_in;
    wire logic [13:0] dac_code_reg;
    wire logic dac_valid_reg, sample_taken_reg, clk_1x_out_reg, multiplier_lock_indicator_reg;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    logic ind_a;
    always #2 clk_sys = ~clk_sys;
    izs_interp_datapath dut (.clk_sys, .rst_n, .ce(1'b1), .sample_in, .filter_response_select, .zero_stuff_select,
        .div_reset, .mult_enable, .dac_code_reg, .dac_valid_reg, .sample_taken_reg, .clk_1x_out_reg,
        .multiplier_lock_indicator_reg);
    izs_src_model src (.clk_sys, .sample_taken_reg, .sample_in);
    task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic do_reset(input logic [13:0] imp);
        rst_n = 1'b0;
        for (int i = 0; i < 64; i++) src.mem[i] = 14'h2000;
        src.mem[2] = imp;
        repeat (4) @(negedge clk_sys);
        src.idx = 0;
        rst_n = 1'b1;
    endtask
    // Impulse at sample 2 must reach the centre slot ten samples later
    task automatic run_mode(input logic fsel, input logic zsel, input logic [13:0] imp, input logic [13:0] exp_c);
        int n;
        int t;
        n = 0;
        t = 0;
        filter_response_select = fsel;
        zero_stuff_select = zsel;
        do_reset(imp);
        while (n < 30 && t < 400) begin
            @(negedge clk_sys);
            t++;
            if (sample_taken_reg === 1'b1) begin
                // Centre code stands at the pulse (plain) or three cycles later (stuffed)
                repeat (zsel ? 3 : 0) @(negedge clk_sys);
                check("centre code", dac_code_reg, n == (zsel ? 12 : 13) ? exp_c : 14'h2000);
                if (n == 5 || n == 25) check("valid", {13'h0, dac_valid_reg}, {13'h0, n == 25});
                n++;
            end
        end
        check("sample count", 14'(n), 14'h1E);
        $display("mode %b%b done", fsel, zsel);
    endtask
    task automatic misc_ctrl();
        zero_stuff_select = 1'b0;
        do_reset(14'h2000);
        mult_enable = 1'b1;
        repeat (20) @(negedge clk_sys);
        check("lock", {13'h0, multiplier_lock_indicator_reg}, 14'h1);
        for (int i = 0; i < 4 && sample_taken_reg !== 1'b1; i++) @(negedge clk_sys);
        div_reset = 1'b1;
        @(negedge clk_sys);
        check("realign load", {13'h0, sample_taken_reg}, 14'h1);
        div_reset = 1'b0;
        @(negedge clk_sys);
        check("lock cleared", {13'h0, multiplier_lock_indicator_reg}, 14'h0);
        check("realign gap", {13'h0, sample_taken_reg}, 14'h0);
        mult_enable = 1'b0;
        @(negedge clk_sys);
        check("realign next", {13'h0, sample_taken_reg}, 14'h1);
        ind_a = multiplier_lock_indicator_reg;
        @(negedge clk_sys);
        check("indicator toggle", {13'h0, ind_a ^ multiplier_lock_indicator_reg}, 14'h1);
        $display("control test done");
    endtask
    initial begin
        run_mode(1'b0, 1'b0, 14'h2FA0, 14'h2FA0);
        run_mode(1'b1, 1'b0, 14'h2FA0, 14'h1060);
        run_mode(1'b0, 1'b1, 14'h0000, 14'h0000);
        run_mode(1'b1, 1'b1, 14'h0000, 14'h3FFF);
        misc_ctrl();
        print_verdict();
    end
endmodule // izs_interp_datapath_tb
bind izs_interp_datapath izs_dp_monitor mon (.clk_sys, .rst_n, .zero_stuff_select, .div_reset, .mult_enable,
    .dac_code_reg, .dac_valid_reg, .sample_taken_reg, .clk_1x_out_reg, .multiplier_lock_indicator_reg);
`default_nettype wire
